// ===== hw/dac_regs_cfg.svh
// Offsets, field positions, reset values and widths of the channel code and pair trim registers.
// Assumes it is included once per compilation unit by its bare name.
`ifndef DAC_REGS_CFG_SVH
`define DAC_REGS_CFG_SVH

`define ADDR_W 6
`define TRIG_ADDR 6'h0e
`define SYNC_LOAD_BIT 4
`define CODE_PAGE 2'h1
`define TRIM_BASE 6'h20
`define TRIM_LAST 6'h23
`define UPPER_TRIM_MSB 15
`define UPPER_TRIM_LSB 8
`define LOWER_TRIM_MSB 7
`define LOWER_TRIM_LSB 0
`define CODE_RESET 16'h0000
`define TRIM_REG_RESET 16'h0000
`define TRIM_RESET 8'h00
`define FULL_RES 16
`define NUM_CHAN 16
`define NUM_PAIR 8
`define NUM_TRIM_REG 4

`endif

// ===== hw/dac_regs_pkg.sv
// Types shared by the channel code register bank and its pair trim unit.
// Assumes dac_regs_cfg.svh is available on the include path.
package dac_regs_pkg;
   typedef logic [15:0] code_t;
   typedef logic [7:0] trim_t;
   typedef logic [5:0] addr_t;
   // Per-channel toggle source: off, or one of three toggle pins
   typedef enum logic [1:0] {
      TOG_OFF = 2'b00,
      TOG_PIN0 = 2'b01,
      TOG_PIN1 = 2'b10,
      TOG_PIN2 = 2'b11
   } tog_sel_t;
endpackage

// ===== hw/pair_trim_if.sv
// Carrier between the register bank and the pair trim unit.
// Assumes a single clock domain; the unit is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface pair_trim_if;
   logic clk; // Only the trim unit's checks use it
   logic [7:0] raw [8];
   logic [7:0] diffEn;
   logic [7:0] trim [8];
   modport calc (input clk, input raw, input diffEn, output trim);
   modport user (output clk, output raw, output diffEn, input trim);
endinterface
`default_nettype wire

// ===== hw/pair_trim_calc.sv
// Pair trim unit: turns each raw 8-bit pair offset into the trim actually used.
// Assumes the register bank latches the result; no state is held here.
`timescale 1ns/1ps
`default_nettype none
`include "dac_regs_cfg.svh"
module pair_trim_calc #(
   parameter int RESOLUTION = 16
)(
   pair_trim_if.calc tp
);
   import dac_regs_pkg::*;

   // Low bits below the converter's resolution are don't-care
   localparam trim_t TRIM_MASK = trim_t'(8'hff << (`FULL_RES - RESOLUTION));

   function automatic trim_t trimFor(input trim_t raw, input logic diffOn);
      trimFor = diffOn ? (raw & TRIM_MASK) : `TRIM_RESET;
   endfunction

   // Two's-complement trim, upper 8, 6 or 4 bits kept
   for (genvar p = 0; p < `NUM_PAIR; p++) begin : g_pair
      assign tp.trim[p] = trimFor(tp.raw[p], tp.diffEn[p]);
   end

   property p_trimLowBits;
      @(posedge tp.clk) (tp.trim[0] & ~TRIM_MASK) == 8'h00;
   endproperty
   a_trimLowBits: assert property (p_trimLowBits) else $error("trim low bits not ignored");

   property p_trimOff;
      @(posedge tp.clk) !tp.diffEn[7] |-> tp.trim[7] == 8'h00;
   endproperty
   a_trimOff: assert property (p_trimOff) else $error("trim active outside differential mode");
endmodule
`default_nettype wire

// ===== hw/dac_code_regs.sv
// Channel code and pair trim register bank of a sixteen-channel converter.
// Assumes the serial frame decoder delivers one-cycle register writes and reads on clk.
`timescale 1ns/1ps
`default_nettype none
`include "dac_regs_cfg.svh"
module dac_code_regs #(
   parameter int RESOLUTION = 16
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wrEn,
   input wire dac_regs_pkg::addr_t wrAddr,
   input wire dac_regs_pkg::code_t wrData,
   input wire logic rdEn,
   input wire dac_regs_pkg::addr_t rdAddr,
   output dac_regs_pkg::code_t rdData,
   output logic rdValid,
   input wire logic [15:0] syncUpdateSetup,
   input wire logic [31:0] toggleSetup,
   input wire logic [7:0] diffPairs,
   input wire logic [2:0] togglePin,
   output logic [255:0] chanCode,
   output logic [63:0] pairTrim
);
   import dac_regs_pkg::*;

   localparam code_t CODE_MASK = code_t'(16'hffff << (`FULL_RES - RESOLUTION));

   code_t pendA_reg [16], pendA_next [16];
   code_t pendB_reg [16], pendB_next [16];
   code_t actA_reg [16], actA_next [16];
   code_t actB_reg [16], actB_next [16];
   code_t trimReg_reg [4], trimReg_next [4];
   trim_t actTrim_reg [8], actTrim_next [8];
   logic [255:0] chanCode_next;
   logic [63:0] pairTrim_next;
   code_t rdData_next;
   logic [2:0] pinMeta_reg, pinSync_reg;
   logic codeWr, loadPulse;

   pair_trim_if tp ();

   // Clock handed to the trim unit for its checks only
   assign tp.clk = clk;

   pair_trim_calc #(.RESOLUTION(RESOLUTION)) u_trim (.tp(tp));

   function automatic logic isCodeWr(input addr_t a);
      isCodeWr = (a[5:4] == `CODE_PAGE);
   endfunction

   function automatic logic isTrimAddr(input addr_t a);
      isTrimAddr = (a >= `TRIM_BASE) && (a <= `TRIM_LAST);
   endfunction

   function automatic logic toggleHigh(input logic [1:0] sel, input logic [2:0] pins);
      toggleHigh = (tog_sel_t'(sel) != TOG_OFF) && pins[sel - 2'd1];
   endfunction

   // Register decode of the host write
   assign codeWr = wrEn && isCodeWr(wrAddr);
   assign loadPulse = wrEn && (wrAddr == `TRIG_ADDR) && wrData[`SYNC_LOAD_BIT];

   // Map trim fields to pairs; pair 7 is the upper field of the first register
   always_comb begin
      for (int p = 0; p < `NUM_PAIR; p++) begin
         if (p % 2 == 1) begin
            tp.raw[p] = trimReg_reg[3 - p / 2][`UPPER_TRIM_MSB:`UPPER_TRIM_LSB];
         end else begin
            tp.raw[p] = trimReg_reg[3 - p / 2][`LOWER_TRIM_MSB:`LOWER_TRIM_LSB];
         end
      end
      tp.diffEn = diffPairs;
   end

   // Next values of the code, trim and output registers
   always_comb begin
      pendA_next = pendA_reg;
      pendB_next = pendB_reg;
      actA_next = actA_reg;
      actB_next = actB_reg;
      trimReg_next = trimReg_reg;
      actTrim_next = actTrim_reg;
      chanCode_next = chanCode;
      pairTrim_next = pairTrim;
      rdData_next = 16'h0000;
      for (int k = 0; k < `NUM_TRIM_REG; k++) begin
         if (wrEn && wrAddr == `TRIM_BASE + addr_t'(k)) begin
            trimReg_next[k] = wrData;
         end
      end
      for (int n = 0; n < `NUM_CHAN; n++) begin
         // Writes to the second channel of a differential pair are dropped
         if (codeWr && wrAddr[3:0] == 4'(n) && !((n % 2 == 1) && diffPairs[n / 2])) begin
            if (toggleSetup[2 * n +: 2] != 2'b00) begin
               pendB_next[n] = wrData & CODE_MASK;
               if (!syncUpdateSetup[n]) begin
                  actB_next[n] = wrData & CODE_MASK;
               end
            end else begin
               pendA_next[n] = wrData & CODE_MASK;
               if (!syncUpdateSetup[n]) begin
                  actA_next[n] = wrData & CODE_MASK;
               end
            end
            // A trim change lands only with an immediate code write to the pair's first channel or a load
            if (n % 2 == 0 && !syncUpdateSetup[n]) begin
               actTrim_next[n / 2] = tp.trim[n / 2];
            end
         end
         // Software load moves every synchronous channel at once
         if (loadPulse && syncUpdateSetup[n]) begin
            actA_next[n] = pendA_reg[n];
            actB_next[n] = pendB_reg[n];
            if (n % 2 == 0) begin
               actTrim_next[n / 2] = tp.trim[n / 2];
            end
         end
      end
      // Output codes; the second channel of a differential pair follows the first
      for (int n = 0; n < `NUM_CHAN; n++) begin
         if ((n % 2 == 1) && diffPairs[n / 2]) begin
            chanCode_next[16 * n +: 16] = chanCode_next[16 * (n - 1) +: 16];
         end else if (toggleHigh(toggleSetup[2 * n +: 2], pinSync_reg)) begin
            chanCode_next[16 * n +: 16] = actB_reg[n];
         end else begin
            chanCode_next[16 * n +: 16] = actA_reg[n];
         end
      end
      for (int p = 0; p < `NUM_PAIR; p++) begin
         pairTrim_next[8 * p +: 8] = diffPairs[p] ? actTrim_reg[p] : `TRIM_RESET;
      end
      // Only the trim registers read back; code registers are write-only
      if (isTrimAddr(rdAddr)) begin
         rdData_next = trimReg_reg[rdAddr[1:0]];
      end
   end

   // Register stage; toggle pins pass two flops before use
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int n = 0; n < `NUM_CHAN; n++) begin
            pendA_reg[n] <= `CODE_RESET;
            pendB_reg[n] <= `CODE_RESET;
            actA_reg[n] <= `CODE_RESET;
            actB_reg[n] <= `CODE_RESET;
         end
         for (int k = 0; k < `NUM_TRIM_REG; k++) begin
            trimReg_reg[k] <= `TRIM_REG_RESET;
         end
         for (int p = 0; p < `NUM_PAIR; p++) begin
            actTrim_reg[p] <= `TRIM_RESET;
         end
         chanCode <= 256'h0;
         pairTrim <= 64'h0;
         rdData <= 16'h0000;
         rdValid <= 1'b0;
         pinMeta_reg <= 3'h0;
         pinSync_reg <= 3'h0;
      end else begin
         pendA_reg <= pendA_next;
         pendB_reg <= pendB_next;
         actA_reg <= actA_next;
         actB_reg <= actB_next;
         trimReg_reg <= trimReg_next;
         actTrim_reg <= actTrim_next;
         chanCode <= chanCode_next;
         pairTrim <= pairTrim_next;
         rdData <= rdData_next;
         rdValid <= rdEn;
         pinMeta_reg <= togglePin;
         pinSync_reg <= pinMeta_reg;
      end
   end

   property p_lowBitsZero;
      @(posedge clk) disable iff (!rst_n) (chanCode[15:0] & ~CODE_MASK) == 16'h0000;
   endproperty
   a_lowBitsZero: assert property (p_lowBitsZero) else $error("code low bits not ignored");

   property p_directWrite;
      @(posedge clk) disable iff (!rst_n)
         (codeWr && wrAddr[3:0] == 4'h0 && !syncUpdateSetup[0] && toggleSetup[1:0] == 2'b00)
         |=> ##1 chanCode[15:0] == ($past(wrData, 2) & CODE_MASK);
   endproperty
   a_directWrite: assert property (p_directWrite) else $error("immediate write lost");

   property p_oddDropped;
      @(posedge clk) disable iff (!rst_n)
         (codeWr && wrAddr[3:0] == 4'h1 && diffPairs[0]) |=> $stable(pendA_reg[1]) && $stable(pendB_reg[1]);
   endproperty
   a_oddDropped: assert property (p_oddDropped) else $error("second pair channel took a write");

   property p_syncHold;
      @(posedge clk) disable iff (!rst_n)
         (codeWr && wrAddr[3:0] == 4'h2 && syncUpdateSetup[2] && !loadPulse) |=> $stable(actA_reg[2]);
   endproperty
   a_syncHold: assert property (p_syncHold) else $error("synchronous channel updated early");

   property p_load;
      @(posedge clk) disable iff (!rst_n)
         (loadPulse && syncUpdateSetup[2]) |=> actA_reg[2] == $past(pendA_reg[2]);
   endproperty
   a_load: assert property (p_load) else $error("load did not transfer pending code");

   property p_toggle;
      @(posedge clk) disable iff (!rst_n)
         (toggleSetup[9:8] == 2'b01 && !diffPairs[2]) |=>
         chanCode[79:64] == ($past(pinSync_reg[0]) ? $past(actB_reg[4]) : $past(actA_reg[4]));
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle output not following pin");

   property p_trimMap;
      @(posedge clk) disable iff (!rst_n)
         (wrEn && wrAddr == `TRIM_BASE) |=> tp.raw[7] == $past(wrData[15:8]) && tp.raw[6] == $past(wrData[7:0]);
   endproperty
   a_trimMap: assert property (p_trimMap) else $error("trim field mapped to wrong pair");

   property p_trimNeedsRewrite;
      @(posedge clk) disable iff (!rst_n)
         (wrEn && wrAddr == `TRIM_BASE && !codeWr && !loadPulse) |=> $stable(actTrim_reg[7]);
   endproperty
   a_trimNeedsRewrite: assert property (p_trimNeedsRewrite) else $error("trim applied without rewrite");

   property p_trimFull;
      @(posedge clk) disable iff (!rst_n) (RESOLUTION == 16) |-> tp.trim[0] == (diffPairs[0] ? tp.raw[0] : 8'h00);
   endproperty
   a_trimFull: assert property (p_trimFull) else $error("full-resolution trim altered");
endmodule
`default_nettype wire

// ===== sim/host_model.sv
// Host controller model: issues one-cycle register writes and reads.
// Assumes the clock is shared with the register bank and that requests launch on falling edges.
`timescale 1ns/1ps
`default_nettype none
module host_model
   import dac_regs_pkg::*;
(
   input wire logic clk,
   output logic wrEn,
   output dac_regs_pkg::addr_t wrAddr,
   output dac_regs_pkg::code_t wrData,
   output logic rdEn,
   output dac_regs_pkg::addr_t rdAddr,
   input wire dac_regs_pkg::code_t rdData,
   input wire logic rdValid
);
   // Idle bus values at time zero
   initial begin
      wrEn = 1'b0;
      wrAddr = 6'h00;
      wrData = 16'h0000;
      rdEn = 1'b0;
      rdAddr = 6'h00;
   end

   // Held across the taking edge; released data is inverted so stale values never match
   task automatic wr(input addr_t a, input code_t d);
      @(negedge clk);
      wrEn = 1'b1;
      wrAddr = a;
      wrData = d;
      @(negedge clk);
      wrEn = 1'b0;
      wrAddr = ~a;
      wrData = ~d;
   endtask

   // Answer is registered at the taking edge, so sample it at the next falling edge
   task automatic rd(input addr_t a, output code_t q, output logic v);
      @(negedge clk);
      rdEn = 1'b1;
      rdAddr = a;
      @(negedge clk);
      q = rdData;
      v = rdValid;
      rdEn = 1'b0;
      rdAddr = ~a;
   endtask
endmodule
`default_nettype wire

// ===== sim/dac_code_and_pair_offset_regs_bench.sv
// Self-checking bench for the channel code and pair trim register bank at 14-bit resolution,
// with 16-bit and 12-bit builds on the same bus for the resolution-dependent checks.
// Assumes the host model drives the register strobes and the bench drives config and pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
   $display("mismatch %s expected %h seen %h", n, e, g); end end
module dac_code_and_pair_offset_regs_bench;
   import dac_regs_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wrEn, rdEn, rdValid, v;
   addr_t wrAddr, rdAddr;
   code_t wrData, rdData, q;
   logic [15:0] syncUpdateSetup = 16'h0000;
   logic [31:0] toggleSetup = 32'h00000000;
   logic [7:0] diffPairs = 8'h00;
   logic [2:0] togglePin = 3'h0;
   logic [255:0] chanCode;
   logic [63:0] pairTrim;
   logic [255:0] chanCode16, chanCode12;
   logic [63:0] pairTrim16, pairTrim12;
   int failures = 0;
   int num_checks = 0;

   always #5 clk = ~clk;

   host_model i_host_model (.clk(clk), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData),
      .rdEn(rdEn), .rdAddr(rdAddr), .rdData(rdData), .rdValid(rdValid));

   // 14-bit build: code mask fffc, trim mask fc
   dac_code_regs #(.RESOLUTION(14)) i_dac_code_regs (.clk(clk), .rst_n(rst_n),
      .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .rdEn(rdEn), .rdAddr(rdAddr),
      .rdData(rdData), .rdValid(rdValid), .syncUpdateSetup(syncUpdateSetup),
      .toggleSetup(toggleSetup), .diffPairs(diffPairs), .togglePin(togglePin),
      .chanCode(chanCode), .pairTrim(pairTrim));

   // Full and 12-bit builds see the same writes; only their outputs are judged
   dac_code_regs #(.RESOLUTION(16)) i_dac_code_regs_16 (.clk(clk), .rst_n(rst_n),
      .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .rdEn(rdEn), .rdAddr(rdAddr),
      .rdData(), .rdValid(), .syncUpdateSetup(syncUpdateSetup),
      .toggleSetup(toggleSetup), .diffPairs(diffPairs), .togglePin(togglePin),
      .chanCode(chanCode16), .pairTrim(pairTrim16));

   dac_code_regs #(.RESOLUTION(12)) i_dac_code_regs_12 (.clk(clk), .rst_n(rst_n),
      .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .rdEn(rdEn), .rdAddr(rdAddr),
      .rdData(), .rdValid(), .syncUpdateSetup(syncUpdateSetup),
      .toggleSetup(toggleSetup), .diffPairs(diffPairs), .togglePin(togglePin),
      .chanCode(chanCode12), .pairTrim(pairTrim12));

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Reset state and write-only or unmapped reads answering zero
   task automatic test_reset_reads;
      `CHK("codes at reset", 256'h0, chanCode)
      i_host_model.rd(6'h20, q, v);
      `CHK("trim reg reset", 16'h0000, q)
      i_host_model.rd(6'h10, q, v);
      `CHK("code reg read", 16'h0000, q)
      `CHK("read valid", 1'b1, v)
      i_host_model.rd(6'h3f, q, v);
      `CHK("unmapped read", 16'h0000, q)
      $display("test reset_reads done");
   endtask

   // Immediate code write keeps only the upper 14 bits
   task automatic test_code_mask;
      i_host_model.wr(6'h13, 16'hffff);
      tick(3);
      `CHK("ch3 code", 16'hfffc, chanCode[48 +: 16])
      `CHK("ch3 code 16b", 16'hffff, chanCode16[48 +: 16])
      `CHK("ch3 code 12b", 16'hfff0, chanCode12[48 +: 16])
      $display("test code_mask done");
   endtask

   // Pair 0: odd write dropped, lower field trim, rewrite applies it
   task automatic test_diff_pair0;
      diffPairs = 8'h01;
      i_host_model.wr(6'h23, 16'h0087);
      i_host_model.wr(6'h11, 16'h5555);
      i_host_model.wr(6'h10, 16'h1237);
      tick(3);
      `CHK("ch0 code", 16'h1234, chanCode[0 +: 16])
      `CHK("ch1 code", 16'h1234, chanCode[16 +: 16])
      `CHK("pair0 trim", 8'h84, pairTrim[0 +: 8])
      `CHK("ch0 code 16b", 16'h1237, chanCode16[0 +: 16])
      `CHK("pair0 trim 16b", 8'h87, pairTrim16[0 +: 8])
      `CHK("ch0 code 12b", 16'h1230, chanCode12[0 +: 16])
      `CHK("pair0 trim 12b", 8'h80, pairTrim12[0 +: 8])
      i_host_model.rd(6'h23, q, v);
      `CHK("trim reg 3", 16'h0087, q)
      $display("test diff_pair0 done");
   endtask

   // Pair 7 upper field: no effect until differential and rewritten
   task automatic test_pair7;
      i_host_model.wr(6'h20, 16'h7f00);
      i_host_model.wr(6'h1e, 16'hffff);
      tick(3);
      `CHK("pair7 trim off", 8'h00, pairTrim[56 +: 8])
      diffPairs = 8'h81;
      tick(3);
      `CHK("pair7 no rewrite", 8'h00, pairTrim[56 +: 8])
      i_host_model.wr(6'h1e, 16'h8003); // Host rewrites code after trim change
      tick(3);
      `CHK("pair7 trim", 8'h7c, pairTrim[56 +: 8])
      `CHK("ch15 code", 16'h8000, chanCode[240 +: 16])
      $display("test pair7 done");
   endtask

   // Synchronous channel waits for the load bit
   task automatic test_sync_load;
      syncUpdateSetup = 16'h0004;
      i_host_model.wr(6'h12, 16'habcd);
      tick(3);
      `CHK("ch2 pending", 16'h0000, chanCode[32 +: 16])
      i_host_model.wr(6'h0e, 16'h0010);
      tick(3);
      `CHK("ch2 loaded", 16'habcc, chanCode[32 +: 16])
      $display("test sync_load done");
   endtask

   // Toggle channels follow their own pins between their two codes
   task automatic test_toggle;
      i_host_model.wr(6'h14, 16'h1111);
      i_host_model.wr(6'h15, 16'h3333);
      i_host_model.wr(6'h16, 16'h5555);
      toggleSetup = 32'h00003900; // Pin 0 drives ch4, pin 1 ch5, pin 2 ch6
      i_host_model.wr(6'h14, 16'h2222);
      i_host_model.wr(6'h15, 16'h4444);
      i_host_model.wr(6'h16, 16'h6666);
      togglePin = 3'h1;
      tick(4);
      `CHK("ch4 high code", 16'h2220, chanCode[64 +: 16])
      `CHK("ch5 low code", 16'h3330, chanCode[80 +: 16])
      `CHK("ch6 low code", 16'h5554, chanCode[96 +: 16])
      togglePin = 3'h6;
      tick(4);
      `CHK("ch4 low code", 16'h1110, chanCode[64 +: 16])
      `CHK("ch5 high code", 16'h4444, chanCode[80 +: 16])
      `CHK("ch6 high code", 16'h6664, chanCode[96 +: 16])
      $display("test toggle done");
   endtask

   // Watchdog well beyond the fewer than a hundred cycles the tests need
   initial begin
      #100000;
      failures++;
      end_sim();
   end

   initial begin
      tick(8);
      rst_n = 1'b1;
      tick(1);
      test_reset_reads();
      test_code_mask();
      test_diff_pair0();
      test_pair7();
      test_sync_load();
      test_toggle();
      end_sim();
   end
endmodule
`default_nettype wire
